//--- core/adcm_regs.svh
/*
 * Constants of the auxiliary data channel mux: register offset, reset
 * values, frame geometry and return slot schedule.
 * Assumes it is included by bare name from the core files.
 */
`ifndef ADCM_REGS_SVH
`define ADCM_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define ADCM_REG_PIN_STATE      8'h07
`define ADCM_PIN_STATE_RST      4'h0
`define ADCM_RSVD_BITS          4'h0
`define ADCM_UNMAPPED_DATA      8'h00
`define ADCM_BYTE_RST           8'h00
`define ADCM_GPIN_WIDTH         4

// ****************************************
// Frame timing, in audio samples and forward packets
// ****************************************
`define ADCM_FRAME_SAMPLES      128
`define ADCM_FWD_PKTS           4
`define ADCM_SLOT_SAMPLES       32

// ****************************************
// Return channel
// ****************************************
`define ADCM_RET_BYTES          5
`define ADCM_ALLOC_FRAMES       10
`define ADCM_RET_SCHED          20'h373B7
`define ADCM_MST_SYNC           8'hA5
`define ADCM_MST_PAYLOAD        8'h02
`define ADCM_MST_NO_PAYLOAD     8'h00

`endif

//--- core/adcm_pkg.sv
/*
 * Types of the auxiliary data channel mux.
 * Assumes nothing of its surroundings.
 */
package adcm_pkg;

	// ****************************************
	// Return packet classes
	// ****************************************
	typedef enum logic [1:0] {
		ADCM_RET_SPARE = 2'b00,
		ADCM_RET_QUAL  = 2'b01,
		ADCM_RET_PORT  = 2'b10,
		ADCM_RET_MAST  = 2'b11
	} adcm_ret_class_t;

endpackage : adcm_pkg

//--- core/adcm_sync.sv
/*
 * Two flip-flop synchroniser, one pair per bit.
 * Assumes asynchronous inputs and the sys_clk domain on the output.
 */
`timescale 1ns/1ns

module adcm_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// ****************************************
	// Per-bit stages
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta;
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					meta <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta <= d[i];
					q[i] <= meta;
				end
			end
		end
	endgenerate

endmodule : adcm_sync

//--- core/adcm_aux_mux.sv
/*
 * Auxiliary data channel mux of the receiver side: input pin state byte,
 * forward byte slots on the audio stream, return packet scheduling.
 * Assumes sample_tick is a one-cycle pulse per audio sample on sys_clk and
 * that the link logic consumes fwd and ret outputs in the cycle shown.
 */
// Functional notes
// - The pin state byte shows the four general inputs in bits 3 to 0.
// - Forward bytes go out in slots embedded in the audio stream.
// - A frame starts every 128 audio samples.
// - Each forward frame holds four packets of one byte each.
// - Frame timing follows any of the 48, 44.1 and 32 kHz sample rates.
// - All forward sources feed one shared queue.
// - A slot with the link down sends nothing, so throughput falls.
// - The return channel sends one five-byte packet per frame.
// - One fifth of return packets carry the link quality value.
// - One tenth of return packets mirror the parallel port.
// - Half of return packets serve the master, two fifths of it payload.
// - One fifth of return packets are spare and carry zeros.
// - The pins drive the byte only when the pin interface is selected.
// - With the slave interface selected the byte holds its last value.
`timescale 1ns/1ns
`include "adcm_regs.svh"

module adcm_aux_mux #(
	parameter int NSRC  = 2,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 nrst,
	// Configuration and pins
	input  wire logic                 gpio_mode,
	input  wire logic [3:0]           general_inputs,
	// Register read port
	input  wire logic [7:0]           reg_addr,
	input  wire logic                 reg_rd,
	output logic      [7:0]           reg_rdata,
	// Audio timing
	input  wire logic                 sample_tick,
	output logic                      frame_start,
	// Forward sources
	input  wire logic [NSRC-1:0]      src_valid,
	input  wire logic [NSRC*8-1:0]    src_data,
	output logic      [NSRC-1:0]      src_ready,
	// Forward link side
	input  wire logic                 link_ok,
	output logic                      fwd_valid,
	output logic      [7:0]           fwd_byte,
	// Return sources
	input  wire logic [7:0]           link_quality_value,
	input  wire logic [7:0]           parallel_port,
	input  wire logic                 mst_valid,
	input  wire logic [7:0]           mst_addr,
	input  wire logic [15:0]          mst_data,
	output logic                      mst_ready,
	// Return link side
	output logic                      ret_valid,
	output adcm_pkg::adcm_ret_class_t ret_class,
	output logic [`ADCM_RET_BYTES*8-1:0] ret_data
);

	localparam int AW = $clog2(DEPTH);
	localparam int SW = $clog2(`ADCM_SLOT_SAMPLES);
	localparam int PW = $clog2(`ADCM_FWD_PKTS);
	localparam logic [SW-1:0] SLOT_LAST = SW'(`ADCM_SLOT_SAMPLES - 1);
	localparam logic [PW-1:0] PKT_LAST  = PW'(`ADCM_FWD_PKTS - 1);
	localparam logic [3:0]    ALLOC_LAST = 4'(`ADCM_ALLOC_FRAMES - 1);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// ****************************************
	// Input pin state byte
	// ****************************************
	logic [3:0] gpin_sync;
	logic [3:0] pin_state;
	logic [3:0] next_pin_state;
	logic [7:0] next_rdata;

	adcm_sync #(.W(`ADCM_GPIN_WIDTH)) u_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.d       (general_inputs),
		.q       (gpin_sync)
	);

	always_comb begin
		// Slave mode keeps the byte readable but cut from its pins
		next_pin_state = gpio_mode ? gpin_sync : pin_state;
		next_rdata = reg_rdata;
		if (reg_rd) begin
			if (reg_addr == `ADCM_REG_PIN_STATE) begin
				next_rdata = {`ADCM_RSVD_BITS, pin_state};
			end else begin
				next_rdata = `ADCM_UNMAPPED_DATA;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin_state <= `ADCM_PIN_STATE_RST;
			reg_rdata <= `ADCM_BYTE_RST;
		end else begin
			pin_state <= next_pin_state;
			reg_rdata <= next_rdata;
		end
	end

	property p_rsvd_zero;
		reg_rdata[7:4] == `ADCM_RSVD_BITS;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved pin state bits not zero");

	property p_pin_follow;
		(gpio_mode && $stable(general_inputs)) [*4]
		|-> pin_state == general_inputs;
	endproperty
	a_pin_follow: assert property (p_pin_follow)
		else $error("pin state does not follow stable inputs");

	property p_pin_hold;
		!gpio_mode |=> $stable(pin_state);
	endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("pin state moved in slave mode");

	// ****************************************
	// Frame and slot timing
	// ****************************************
	logic [SW-1:0] samp_in_slot;
	logic [SW-1:0] next_samp_in_slot;
	logic [PW-1:0] slot_idx;
	logic [PW-1:0] next_slot_idx;
	logic          slot_tick;

	// Sample counts, not time, set the frame, so any audio rate works
	assign slot_tick   = sample_tick && (samp_in_slot == '0);
	assign frame_start = slot_tick && (slot_idx == '0);

	always_comb begin
		next_samp_in_slot = samp_in_slot;
		next_slot_idx = slot_idx;
		if (sample_tick) begin
			if (samp_in_slot == SLOT_LAST) begin
				next_samp_in_slot = '0;
				next_slot_idx = (slot_idx == PKT_LAST) ? '0 : slot_idx + 1'b1;
			end else begin
				next_samp_in_slot = samp_in_slot + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			samp_in_slot <= '0;
			slot_idx <= '0;
		end else begin
			samp_in_slot <= next_samp_in_slot;
			slot_idx <= next_slot_idx;
		end
	end

	// Helper for the frame period check
	logic [7:0] ticks_since;
	logic       seen_frame;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ticks_since <= 8'h00;
			seen_frame <= 1'b0;
		end else if (frame_start) begin
			ticks_since <= 8'h00;
			seen_frame <= 1'b1;
		end else if (sample_tick) begin
			ticks_since <= ticks_since + 8'h01;
		end
	end

	property p_frame_period;
		frame_start && seen_frame
		|-> ticks_since == 8'(`ADCM_FRAME_SAMPLES - 1);
	endproperty
	a_frame_period: assert property (p_frame_period)
		else $error("frame period is not 128 samples");

	// ****************************************
	// Forward shared queue
	// ****************************************
	logic [7:0]    mem [DEPTH];
	logic [7:0]    next_mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0]   count;
	logic [AW:0]   next_count;
	logic          next_fwd_valid;
	logic [7:0]    next_fwd_byte;
	logic [NSRC:0] taken;
	logic [NSRC-1:0] grant;
	logic [7:0]    push_data;
	logic          full;
	logic          empty;
	logic          push;
	logic          pop;

	assign full  = (count == (AW+1)'(DEPTH));
	assign empty = (count == '0);

	// Fixed priority: a busy low index delays the others
	assign taken[0] = 1'b0;
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_src
			assign grant[gi] = src_valid[gi] && !taken[gi];
			assign taken[gi+1] = taken[gi] || src_valid[gi];
			assign src_ready[gi] = grant[gi] && !full;
		end
	endgenerate

	always_comb begin
		push_data = `ADCM_BYTE_RST;
		for (int i = 0; i < NSRC; i++) begin
			if (grant[i]) begin
				push_data = src_data[i*8 +: 8];
			end
		end
	end

	assign push = (|grant) && !full;
	assign pop  = slot_tick && link_ok && !empty;

	always_comb begin
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		next_fwd_valid = pop;
		next_fwd_byte = fwd_byte;
		if (push) begin
			next_mem[wr_ptr] = push_data;
			next_wr_ptr = wr_ptr + 1'b1;
		end
		if (pop) begin
			next_fwd_byte = mem[rd_ptr];
			next_rd_ptr = rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= `ADCM_BYTE_RST;
			end
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			fwd_valid <= 1'b0;
			fwd_byte <= `ADCM_BYTE_RST;
		end else begin
			mem <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			fwd_valid <= next_fwd_valid;
			fwd_byte <= next_fwd_byte;
		end
	end

	property p_full_stall;
		full |-> src_ready == '0;
	endproperty
	a_full_stall: assert property (p_full_stall)
		else $error("queue accepted while full");

	property p_fwd_in_slot;
		fwd_valid |-> $past(slot_tick) && $past(link_ok);
	endproperty
	a_fwd_in_slot: assert property (p_fwd_in_slot)
		else $error("forward byte outside a slot");

	property p_link_down;
		slot_tick && !link_ok |=> !fwd_valid && $stable(rd_ptr);
	endproperty
	a_link_down: assert property (p_link_down)
		else $error("byte sent or dropped with link down");

	// ****************************************
	// Return packet scheduler
	// ****************************************
	logic [3:0]                   alloc_idx;
	logic [3:0]                   next_alloc_idx;
	adcm_pkg::adcm_ret_class_t    cur_class;
	adcm_pkg::adcm_ret_class_t    next_ret_class;
	logic                         next_ret_valid;
	logic [`ADCM_RET_BYTES*8-1:0] next_ret_data;
	logic [19:0]                  sched;

	assign sched = `ADCM_RET_SCHED;
	// Table order spreads the classes over each ten-frame period
	assign cur_class = adcm_pkg::adcm_ret_class_t'(
		sched[{alloc_idx, 1'b0} +: 2]);
	assign mst_ready = frame_start && (cur_class == adcm_pkg::ADCM_RET_MAST)
		&& mst_valid;

	always_comb begin
		next_alloc_idx = alloc_idx;
		next_ret_valid = frame_start;
		next_ret_class = ret_class;
		next_ret_data = ret_data;
		if (frame_start) begin
			next_alloc_idx = (alloc_idx == ALLOC_LAST) ? '0 : alloc_idx + 1'b1;
			next_ret_class = cur_class;
			next_ret_data = '0;
			case (cur_class)
				adcm_pkg::ADCM_RET_QUAL: begin
					next_ret_data[39:32] = link_quality_value;
				end
				adcm_pkg::ADCM_RET_PORT: begin
					next_ret_data[39:32] = parallel_port;
				end
				adcm_pkg::ADCM_RET_MAST: begin
					// Three overhead bytes, two payload bytes
					next_ret_data[39:32] = `ADCM_MST_SYNC;
					next_ret_data[31:24] = mst_addr;
					next_ret_data[23:16] = mst_valid ? `ADCM_MST_PAYLOAD
						: `ADCM_MST_NO_PAYLOAD;
					next_ret_data[15:0] = mst_valid ? mst_data : 16'h0000;
				end
				default: begin
					next_ret_data = '0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			alloc_idx <= '0;
			ret_valid <= 1'b0;
			ret_class <= adcm_pkg::ADCM_RET_SPARE;
			ret_data <= '0;
		end else begin
			alloc_idx <= next_alloc_idx;
			ret_valid <= next_ret_valid;
			ret_class <= next_ret_class;
			ret_data <= next_ret_data;
		end
	end

	property p_ret_per_frame;
		frame_start |=> ret_valid ##1 !ret_valid;
	endproperty
	a_ret_per_frame: assert property (p_ret_per_frame)
		else $error("return packet not one per frame");

	property p_quality;
		ret_valid && ret_class == adcm_pkg::ADCM_RET_QUAL
		|-> ret_data[39:32] == $past(link_quality_value);
	endproperty
	a_quality: assert property (p_quality)
		else $error("quality packet holds wrong value");

	property p_master;
		ret_valid && ret_class == adcm_pkg::ADCM_RET_MAST
		|-> ret_data[39:32] == `ADCM_MST_SYNC
		&& ret_data[31:24] == $past(mst_addr);
	endproperty
	a_master: assert property (p_master)
		else $error("master packet overhead wrong");

	property p_spare;
		ret_valid && ret_class == adcm_pkg::ADCM_RET_SPARE |-> ret_data == '0;
	endproperty
	a_spare: assert property (p_spare)
		else $error("spare packet not zero");

endmodule : adcm_aux_mux

//--- tb/adcm_audio_link.sv
/*
 * Audio side of the link: one sample_tick pulse every four clocks.
 * Assumes the bench clock and reset.
 */
`timescale 1ns/1ns

module adcm_audio_link (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic nrst,
	// Control
	input  wire logic tick_en,
	// Audio timing
	output logic      sample_tick
);
	// ****************************************
	// Sample tick
	// ****************************************
	logic [1:0] div;
	logic       en_q;

	// Enable taken on the rising edge, so a bench write never races it
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			en_q <= 1'b0;
		else
			en_q <= tick_en;
	end

	// Falling edge, so the design never samples a changing tick
	always @(negedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div = 2'h0;
			sample_tick = 1'b0;
		end else begin
			sample_tick = en_q && (div == 2'h3);
			div = en_q ? div + 2'h1 : div;
		end
	end
endmodule : adcm_audio_link

//--- tb/tb_adcm_aux_mux.sv
/*
 * Bench of the auxiliary data channel mux: pin byte, return schedule,
 * forward queue and slots.
 * Assumes one sample_tick every four clocks from the audio model.
 */
`timescale 1ns/1ns
`include "adcm_regs.svh"

module tb_adcm_aux_mux;
	// ****************************************
	// Signals
	// ****************************************
	logic                      sys_clk, nrst, gpio_mode, reg_rd, tick_en;
	logic                      sample_tick, frame_start, link_ok, fwd_valid;
	logic                      mst_valid, mst_ready, ret_valid;
	logic [3:0]                general_inputs;
	logic [7:0]                reg_addr, reg_rdata, fwd_byte, mst_addr;
	logic [7:0]                link_quality_value, parallel_port;
	logic [1:0]                src_valid, src_ready;
	logic [15:0]               src_data, mst_data;
	logic [39:0]               ret_data;
	adcm_pkg::adcm_ret_class_t ret_class;
	logic [7:0]                fwd_log[$];
	int                        mismatches = 0;
	int                        total_checks = 0;
	int                        cyc = 0;
	int                        mst_seen = 0;
	int                        frame_seen = 0;

	adcm_aux_mux #(.NSRC(2), .DEPTH(8)) dut_u (
		.sys_clk, .nrst, .gpio_mode, .general_inputs, .reg_addr, .reg_rd,
		.reg_rdata, .sample_tick, .frame_start, .src_valid, .src_data,
		.src_ready, .link_ok, .fwd_valid, .fwd_byte, .link_quality_value,
		.parallel_port, .mst_valid, .mst_addr, .mst_data, .mst_ready,
		.ret_valid, .ret_class, .ret_data
	);

	adcm_audio_link link_u (.sys_clk, .nrst, .tick_en, .sample_tick);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
		cyc <= cyc + 1;

	// Outputs read away from the rising edge, once they have settled
	always @(negedge sys_clk) begin
		if (fwd_valid === 1'b1)
			fwd_log.push_back(fwd_byte);
		#1;
		mst_seen += int'(mst_ready === 1'b1);
		frame_seen += int'(frame_start === 1'b1);
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(string what, logic [39:0] e, logic [39:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic stop_test;
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic rd(logic [7:0] a, logic [7:0] e, string n);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		@(negedge sys_clk);
		chk(n, {32'h0, e}, {32'h0, reg_rdata});
	endtask : rd

	// Holds valid until one rising edge has seen ready, then drops it
	task automatic push(int s, logic [7:0] b);
		int n;
		n = 0;
		@(negedge sys_clk);
		src_valid = 2'(2'h1 << s);
		src_data[s*8 +: 8] = b;
		#1;
		while (src_ready[s] !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			#1;
			n++;
		end
		@(negedge sys_clk);
		src_valid = 2'h0;
		chk("push_taken", 40'h1, 40'(n < 20));
	endtask : push

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_pins;
		rd(`ADCM_REG_PIN_STATE, `ADCM_BYTE_RST, "pin_reset");
		gpio_mode = 1'b1;
		general_inputs = 4'hA;
		repeat (5) @(negedge sys_clk);
		rd(`ADCM_REG_PIN_STATE, 8'h0A, "pin_state");
		rd(8'h06, `ADCM_UNMAPPED_DATA, "unmapped");
		gpio_mode = 1'b0;
		general_inputs = 4'h5;
		repeat (5) @(negedge sys_clk);
		rd(`ADCM_REG_PIN_STATE, 8'h0A, "pin_held");
		gpio_mode = 1'b1;
		repeat (5) @(negedge sys_clk);
		rd(`ADCM_REG_PIN_STATE, 8'h05, "pin_live");
	endtask : t_pins

	task automatic t_ret;
		logic [1:0]  cls[10] = '{3, 1, 3, 2, 3, 0, 3, 1, 3, 0};
		logic [39:0] e;
		int          last, n;
		last = 0;
		for (int i = 0; i < 10; i++) begin
			link_quality_value = 8'h30 + 8'(i);
			parallel_port = 8'h60 + 8'(i);
			mst_addr = 8'h80 + 8'(i);
			mst_data = 16'hC000 + 16'(i);
			mst_valid = (i < 4);
			tick_en = 1'b1;
			n = 0;
			while (ret_valid !== 1'b1 && n < 700) begin
				@(negedge sys_clk);
				n++;
			end
			case (cls[i])
				2'h1: e = {link_quality_value, 32'h0};
				2'h2: e = {parallel_port, 32'h0};
				2'h3: e = {`ADCM_MST_SYNC, mst_addr, mst_valid ?
					`ADCM_MST_PAYLOAD : `ADCM_MST_NO_PAYLOAD,
					mst_valid ? mst_data : 16'h0};
				default: e = 40'h0;
			endcase
			if (i > 0)
				chk("frame_period", 40'h200, 40'(cyc - last));
			last = cyc;
			chk("ret_class", 40'(cls[i]), 40'(ret_class));
			chk("ret_data", e, ret_data);
			@(negedge sys_clk);
		end
		chk("mst_taken", 40'h2, 40'(mst_seen));
		chk("frames", 40'hA, 40'(frame_seen));
	endtask : t_ret

	task automatic t_fwd;
		tick_en = 1'b0;
		link_ok = 1'b0;
		for (int k = 0; k < 8; k++)
			push(k % 2, 8'h40 + 8'(k));
		@(negedge sys_clk);
		src_valid = 2'h1;
		src_data[7:0] = 8'h99;
		@(negedge sys_clk);
		chk("ready_full", 40'h0, 40'(src_ready));
		src_valid = 2'h0;
		fwd_log.delete();
		tick_en = 1'b1;
		repeat (512) @(negedge sys_clk);
		chk("fwd_link_down", 40'h0, 40'(fwd_log.size()));
		link_ok = 1'b1;
		repeat (513) @(negedge sys_clk);
		chk("fwd_per_frame", 40'h4, 40'(fwd_log.size()));
		repeat (512) @(negedge sys_clk);
		chk("fwd_total", 40'h8, 40'(fwd_log.size()));
		for (int k = 0; k < 8 && k < fwd_log.size(); k++)
			chk("fwd_byte", 40'(8'h40 + 8'(k)), 40'(fwd_log[k]));
	endtask : t_fwd

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		nrst = 1'b0;
		{gpio_mode, reg_rd, tick_en, link_ok, mst_valid} = 5'h0;
		general_inputs = 4'h0;
		{reg_addr, link_quality_value, parallel_port, mst_addr} = 32'h0;
		src_valid = 2'h0;
		src_data = 16'h0;
		mst_data = 16'h0;
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
		t_pins();
		t_ret();
		t_fwd();
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		stop_test();
	end
endmodule : tb_adcm_aux_mux
